//--- shared/crg_pkg.sv
package crg_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_CTL0 = 8'h34;
    localparam logic [7:0] IDX_CTL1 = 8'h35;
    localparam logic [7:0] IDX_MULT = 8'h36;
    localparam logic [7:0] IDX_FLAGS = 8'h37;
    localparam logic [7:0] IDX_TRIM_HI = 8'h38;
    localparam logic [7:0] IDX_TRIM_LO = 8'h39;
    localparam logic [7:0] IDX_TEST0 = 8'h3A;
    localparam logic [7:0] IDX_TEST1 = 8'h3B;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTL1_LOCK_IE_BIT = 1;
    localparam int FLG_POWER_ON_BIT = 6;
    localparam int FLG_LOCK_IF_BIT = 4;
    localparam int FLG_LOCK_ST_BIT = 3;
    localparam int FLG_ILLEGAL_BIT = 2;
    localparam int FLG_OSC_UP_BIT = 1;
    localparam logic [7:0] CTL0_RESET = 8'h00;
    localparam logic [3:0] BUS_DIV_RESET = 4'h0;
    localparam logic [6:0] MULT_RESET = 7'h00;
    localparam logic [8:0] TRIM_RESET = 9'h100;
    localparam logic [2:0] REF_DIV_RESERVED = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int OSC_MON_NS = 1000;
    localparam int OSC_MON_CYC = OSC_MON_NS / CLK_PERIOD_NS;
    localparam int RST_STRETCH_NS = 3200;
    localparam int RST_STRETCH_CYC = (RST_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_INTERNAL = 2'b00,
        MODE_EXTERNAL = 2'b01,
        MODE_BYPASS = 2'b10
    } crg_mode_t;

    typedef struct packed {
        logic osc_enable;
        logic [2:0] ref_divider;
        logic bus_clock_source;
        logic loop_ref_select;
        logic low_band_filter_sel;
        logic unused;
    } crg_ctl0_t;

    typedef struct packed {
        logic stop_req;
        logic wake;
        logic irc_keep;
    } crg_power_t;

    typedef struct packed {
        logic power_on;
        logic illegal_access;
        logic watchdog_timeout;
    } crg_reset_src_t;

endpackage

//--- core/crg_top.sv
// Operation
// - Reset leaves internal-reference loop mode, bus clock from controlled oscillator.
// - Oscillator enabled, divided and chosen as loop reference gives external loop mode.
// - Oscillator chosen as bus basis gives bypass, controlled oscillator stopped.
// - Wait mode behaves exactly like run mode.
// - Stop gates bus clock, oscillator, its monitor and controlled oscillator.
// - In stop the internal reference runs while a peripheral requests it.
// - Power-on, illegal access, watchdog, monitor fail or reset pin cause system reset.
// - Enabled monitor detects oscillator loss and triggers system reset, with no cause flag.
// - Lock interrupt raised on entering and on leaving lock.
// - Low reset pin asynchronously returns configuration, lock and clock controls, not the cause flags, to start-up state.
// - Reset pin driven low open-drain while internal or power-on reset triggered.
// - Clock switch picks bus basis, then programmable bus divider.
// - Loop holds controlled oscillator between 32 and 40 MHz via multiplier.
// - Internal reference trim is writable and loadable from factory data.
// - Loop reference selectable between internal reference and oscillator.
// - Oscillator selections written to one only when oscillator has started.
// - Bus basis selection cleared when oscillator disabled or stop entered.
// - Reference divider codes 0-6 give 128..512; code 7 reserved.
// - Writing first control or multiplier register clears lock status, no flag.
//
// The APB slave port is this design's own decision.
module crg_top (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock activity: one-cycle ticks, then start and lock levels
    input wire logic osc_tick_i,
    input wire logic dco_tick_i,
    input wire logic irc_tick_i,
    input wire logic osc_started_i,
    input wire logic fll_locked_i,
    // Power and reset sources
    input wire crg_pkg::crg_power_t power_i,
    input wire crg_pkg::crg_reset_src_t rst_src_i,
    // Factory trim
    input wire logic trim_load_i,
    input wire logic [8:0] trim_value_i,
    // Reset pin, open drain
    input wire logic rst_pin_i,
    output logic rst_pin_o,
    output logic rst_pin_oe,
    // Clock control outputs
    output logic bus_clk_en_o,
    output logic fll_ref_tick_o,
    output crg_pkg::crg_mode_t fll_mode_o,
    output logic dco_en_o,
    output logic osc_en_o,
    output logic osc_mon_en_o,
    output logic osc_low_band_o,
    output logic irc_en_o,
    output logic [6:0] mult_o,
    output logic [8:0] trim_o,
    output logic lock_irq_o
);

    // ------------------------------------------------------------
    // Reset and bus decode
    // ------------------------------------------------------------
    logic cfg_rst_n;
    logic [7:0] idx;
    logic setup;
    logic wr;
    logic [7:0] wdata;
    logic mapped;
    assign cfg_rst_n = presetn & rst_pin_i;
    assign idx = paddr[9:2];
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite && pready;
    assign wdata = pwdata[7:0];
    assign mapped = (idx >= crg_pkg::IDX_CTL0) && (idx <= crg_pkg::IDX_TEST1);

    crg_pkg::crg_ctl0_t ctl0_reg;
    crg_pkg::crg_ctl0_t wctl0;
    logic [3:0] bus_div_reg;
    logic lock_ie_reg;
    logic [6:0] mult_reg;
    logic [8:0] trim_reg;
    logic lock_status_reg;
    logic lock_flag_reg;
    logic power_on_flag_reg;
    logic illegal_flag_reg;
    logic stop_reg;
    logic osc_fail_reg;
    logic lock_clear;
    logic src_any;
    assign wctl0 = crg_pkg::crg_ctl0_t'(wdata);
    assign lock_clear = wr && (idx == crg_pkg::IDX_CTL0 || idx == crg_pkg::IDX_MULT);
    assign src_any = rst_src_i.power_on || rst_src_i.illegal_access
        || rst_src_i.watchdog_timeout || osc_fail_reg;

    // ------------------------------------------------------------
    // First control register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge cfg_rst_n)
    begin
        if (!cfg_rst_n)
        begin
            ctl0_reg <= crg_pkg::crg_ctl0_t'(crg_pkg::CTL0_RESET);
        end
        else if (wr && idx == crg_pkg::IDX_CTL0)
        begin
            ctl0_reg.osc_enable <= wctl0.osc_enable;
            ctl0_reg.ref_divider <= wctl0.ref_divider;
            // Filter band may only change while the oscillator is off
            if (!ctl0_reg.osc_enable)
            begin
                ctl0_reg.low_band_filter_sel <= wctl0.low_band_filter_sel;
            end
            ctl0_reg.bus_clock_source <= wctl0.osc_enable && !stop_reg
                && wctl0.bus_clock_source
                && (osc_started_i || ctl0_reg.bus_clock_source);
            ctl0_reg.loop_ref_select <= wctl0.osc_enable && !stop_reg
                && wctl0.loop_ref_select
                && (osc_started_i || ctl0_reg.loop_ref_select);
        end
        else if (stop_reg)
        begin
            ctl0_reg.bus_clock_source <= 1'b0;
            ctl0_reg.loop_ref_select <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Second control, multiplier and trim registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge cfg_rst_n)
    begin
        if (!cfg_rst_n)
        begin
            bus_div_reg <= crg_pkg::BUS_DIV_RESET;
            lock_ie_reg <= 1'b0;
        end
        else if (wr && idx == crg_pkg::IDX_CTL1)
        begin
            bus_div_reg <= wdata[7:4];
            lock_ie_reg <= wdata[crg_pkg::CTL1_LOCK_IE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge cfg_rst_n)
    begin
        if (!cfg_rst_n)
        begin
            mult_reg <= crg_pkg::MULT_RESET;
        end
        else if (wr && idx == crg_pkg::IDX_MULT)
        begin
            mult_reg <= wdata[6:0];
        end
    end

    // Factory load wins over a software write in the same cycle
    always_ff @(posedge pclk or negedge cfg_rst_n)
    begin
        if (!cfg_rst_n)
        begin
            trim_reg <= crg_pkg::TRIM_RESET;
        end
        else if (trim_load_i)
        begin
            trim_reg <= trim_value_i;
        end
        else if (wr && idx == crg_pkg::IDX_TRIM_HI)
        begin
            trim_reg[8] <= wdata[0];
        end
        else if (wr && idx == crg_pkg::IDX_TRIM_LO)
        begin
            trim_reg[7:0] <= wdata;
        end
    end

    // ------------------------------------------------------------
    // Lock status and lock interrupt flag
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge cfg_rst_n)
    begin
        if (!cfg_rst_n)
        begin
            lock_status_reg <= 1'b0;
        end
        else if (lock_clear)
        begin
            lock_status_reg <= 1'b0;
        end
        else if (!stop_reg && !ctl0_reg.bus_clock_source)
        begin
            lock_status_reg <= fll_locked_i;
        end
    end

    // Set wins over the write-one clear
    always_ff @(posedge pclk or negedge cfg_rst_n)
    begin
        if (!cfg_rst_n)
        begin
            lock_flag_reg <= 1'b0;
        end
        else if (!lock_clear && !stop_reg && !ctl0_reg.bus_clock_source
            && fll_locked_i != lock_status_reg)
        begin
            lock_flag_reg <= 1'b1;
        end
        else if (wr && idx == crg_pkg::IDX_FLAGS && wdata[crg_pkg::FLG_LOCK_IF_BIT])
        begin
            lock_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Reset cause flags, kept across pin resets
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_on_flag_reg <= 1'b1;
            illegal_flag_reg <= 1'b0;
        end
        else
        begin
            if (rst_src_i.power_on)
            begin
                power_on_flag_reg <= 1'b1;
            end
            else if (wr && idx == crg_pkg::IDX_FLAGS && wdata[crg_pkg::FLG_POWER_ON_BIT])
            begin
                power_on_flag_reg <= 1'b0;
            end
            if (rst_src_i.illegal_access)
            begin
                illegal_flag_reg <= 1'b1;
            end
            else if (wr && idx == crg_pkg::IDX_FLAGS && wdata[crg_pkg::FLG_ILLEGAL_BIT])
            begin
                illegal_flag_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Stop handling; wait needs nothing, it is run mode here
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge cfg_rst_n)
    begin
        if (!cfg_rst_n)
        begin
            stop_reg <= 1'b0;
        end
        else if (power_i.stop_req)
        begin
            stop_reg <= 1'b1;
        end
        else if (power_i.wake)
        begin
            stop_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Oscillator monitor
    // ------------------------------------------------------------
    localparam int MON_W = $clog2(crg_pkg::OSC_MON_CYC + 1);
    logic [MON_W-1:0] mon_cnt_reg;
    logic mon_active;
    assign mon_active = ctl0_reg.osc_enable && osc_started_i && !stop_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mon_cnt_reg <= '0;
            osc_fail_reg <= 1'b0;
        end
        else
        begin
            osc_fail_reg <= 1'b0;
            if (!mon_active || osc_tick_i)
            begin
                mon_cnt_reg <= '0;
            end
            else if (mon_cnt_reg == MON_W'(crg_pkg::OSC_MON_CYC))
            begin
                mon_cnt_reg <= '0;
                osc_fail_reg <= 1'b1;
            end
            else
            begin
                mon_cnt_reg <= mon_cnt_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // System reset sequencer and open-drain pin
    // ------------------------------------------------------------
    localparam int RST_W = $clog2(crg_pkg::RST_STRETCH_CYC + 1);
    logic [RST_W-1:0] rst_cnt_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_cnt_reg <= '0;
            rst_pin_oe <= 1'b0;
            rst_pin_o <= 1'b0;
        end
        else
        begin
            rst_pin_o <= 1'b0;
            if (src_any)
            begin
                rst_cnt_reg <= RST_W'(crg_pkg::RST_STRETCH_CYC);
            end
            else if (rst_cnt_reg != '0)
            begin
                rst_cnt_reg <= rst_cnt_reg - 1'b1;
            end
            rst_pin_oe <= src_any || (rst_cnt_reg > RST_W'(1));
        end
    end

    // ------------------------------------------------------------
    // Reference divider and loop reference select
    // ------------------------------------------------------------
    logic [8:0] ref_cnt_reg;
    logic [9:0] ref_div;
    always_comb
    begin
        unique case (ctl0_reg.ref_divider)
            3'h0: ref_div = 10'd128;
            3'h1: ref_div = 10'd160;
            3'h2: ref_div = 10'd192;
            3'h3: ref_div = 10'd256;
            3'h4: ref_div = 10'd320;
            3'h5: ref_div = 10'd384;
            3'h6: ref_div = 10'd512;
            default: ref_div = 10'd0;
        endcase
    end

    always_ff @(posedge pclk or negedge cfg_rst_n)
    begin
        if (!cfg_rst_n)
        begin
            ref_cnt_reg <= '0;
            fll_ref_tick_o <= 1'b0;
        end
        else if (!ctl0_reg.loop_ref_select)
        begin
            ref_cnt_reg <= '0;
            fll_ref_tick_o <= irc_tick_i && !stop_reg;
        end
        else
        begin
            fll_ref_tick_o <= 1'b0;
            if (osc_tick_i && ctl0_reg.ref_divider != crg_pkg::REF_DIV_RESERVED)
            begin
                if ({1'b0, ref_cnt_reg} == ref_div - 10'd1)
                begin
                    ref_cnt_reg <= '0;
                    fll_ref_tick_o <= 1'b1;
                end
                else
                begin
                    ref_cnt_reg <= ref_cnt_reg + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Bus clock switch and divider
    // ------------------------------------------------------------
    logic [3:0] core_cnt_reg;
    logic bus_phase_reg;
    logic src_tick;
    logic core_tick;
    assign src_tick = !stop_reg && (ctl0_reg.bus_clock_source ? osc_tick_i : dco_tick_i);
    assign core_tick = src_tick && core_cnt_reg == bus_div_reg;

    always_ff @(posedge pclk or negedge cfg_rst_n)
    begin
        if (!cfg_rst_n)
        begin
            core_cnt_reg <= '0;
            bus_phase_reg <= 1'b0;
            bus_clk_en_o <= 1'b0;
        end
        else
        begin
            if (src_tick)
            begin
                core_cnt_reg <= core_tick ? 4'h0 : core_cnt_reg + 4'h1;
            end
            if (core_tick)
            begin
                bus_phase_reg <= !bus_phase_reg;
            end
            bus_clk_en_o <= core_tick && bus_phase_reg && !stop_reg;
        end
    end

    // ------------------------------------------------------------
    // Mode and clock enables
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge cfg_rst_n)
    begin
        if (!cfg_rst_n)
        begin
            fll_mode_o <= crg_pkg::MODE_INTERNAL;
            dco_en_o <= 1'b1;
            osc_en_o <= 1'b0;
            osc_mon_en_o <= 1'b0;
            osc_low_band_o <= 1'b0;
            irc_en_o <= 1'b1;
            mult_o <= crg_pkg::MULT_RESET;
            trim_o <= crg_pkg::TRIM_RESET;
            lock_irq_o <= 1'b0;
        end
        else
        begin
            if (ctl0_reg.bus_clock_source)
            begin
                fll_mode_o <= crg_pkg::MODE_BYPASS;
            end
            else if (ctl0_reg.loop_ref_select)
            begin
                fll_mode_o <= crg_pkg::MODE_EXTERNAL;
            end
            else
            begin
                fll_mode_o <= crg_pkg::MODE_INTERNAL;
            end
            dco_en_o <= !stop_reg && !ctl0_reg.bus_clock_source;
            osc_en_o <= !stop_reg && ctl0_reg.osc_enable;
            osc_mon_en_o <= !stop_reg && ctl0_reg.osc_enable;
            osc_low_band_o <= ctl0_reg.low_band_filter_sel;
            irc_en_o <= !stop_reg || power_i.irc_keep;
            mult_o <= mult_reg;
            trim_o <= trim_reg;
            lock_irq_o <= lock_ie_reg && lock_flag_reg;
        end
    end

    // ------------------------------------------------------------
    // APB answer: ready in the first access cycle
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (idx)
            crg_pkg::IDX_CTL0: rd_byte = ctl0_reg;
            crg_pkg::IDX_CTL1: rd_byte = {bus_div_reg, 2'b00, lock_ie_reg, 1'b0};
            crg_pkg::IDX_MULT: rd_byte = {1'b0, mult_reg};
            crg_pkg::IDX_FLAGS: rd_byte = {1'b0, power_on_flag_reg, 1'b0, lock_flag_reg,
                lock_status_reg, illegal_flag_reg, osc_started_i, 1'b0};
            crg_pkg::IDX_TRIM_HI: rd_byte = {7'h00, trim_reg[8]};
            crg_pkg::IDX_TRIM_LO: rd_byte = trim_reg[7:0];
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !mapped;
            if (setup)
            begin
                prdata <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_internal_default:
    assert property (@(posedge pclk) disable iff (!cfg_rst_n)
        !ctl0_reg.bus_clock_source && !ctl0_reg.loop_ref_select
        |=> fll_mode_o == crg_pkg::MODE_INTERNAL)
    else $error("internal loop mode not selected");

    a_external_track:
    assert property (@(posedge pclk) disable iff (!cfg_rst_n)
        ctl0_reg.loop_ref_select && !ctl0_reg.bus_clock_source && !stop_reg
        |=> fll_mode_o == crg_pkg::MODE_EXTERNAL && dco_en_o)
    else $error("external loop mode wrong");

    a_bypass_dco_off:
    assert property (@(posedge pclk) disable iff (!cfg_rst_n)
        ctl0_reg.bus_clock_source |=> fll_mode_o == crg_pkg::MODE_BYPASS && !dco_en_o)
    else $error("bypass mode leaves controlled oscillator on");

    a_stop_gates:
    assert property (@(posedge pclk) disable iff (!cfg_rst_n)
        stop_reg |=> !bus_clk_en_o && !osc_en_o && !osc_mon_en_o && !dco_en_o)
    else $error("clocks running in stop");

    a_irc_kept:
    assert property (@(posedge pclk) disable iff (!cfg_rst_n)
        stop_reg && power_i.irc_keep |=> irc_en_o)
    else $error("reference clock dropped while requested");

    a_reset_pin_drive:
    assert property (@(posedge pclk) disable iff (!presetn)
        $rose(src_any) |=> rst_pin_oe[*8])
    else $error("reset pin not held low after reset source");

    a_monitor_fail:
    assert property (@(posedge pclk) disable iff (!presetn)
        osc_fail_reg |-> $past(mon_active) ##1 rst_pin_oe)
    else $error("monitor failure without reset");

    a_lock_change_flag:
    assert property (@(posedge pclk) disable iff (!cfg_rst_n)
        !lock_clear && !stop_reg && !ctl0_reg.bus_clock_source
        && fll_locked_i != lock_status_reg
        |=> lock_flag_reg ##1 (lock_irq_o == $past(lock_ie_reg)))
    else $error("lock change did not raise flag");

    a_write_clears_lock:
    assert property (@(posedge pclk) disable iff (!cfg_rst_n)
        lock_clear |=> !lock_status_reg && !$rose(lock_flag_reg))
    else $error("control write did not clear lock status");

    a_osc_select_gate:
    assert property (@(posedge pclk) disable iff (!cfg_rst_n)
        wr && idx == crg_pkg::IDX_CTL0 && !osc_started_i && !ctl0_reg.bus_clock_source
        |=> !ctl0_reg.bus_clock_source)
    else $error("bus basis selected before oscillator start");

    a_disable_clears:
    assert property (@(posedge pclk) disable iff (!cfg_rst_n)
        !ctl0_reg.osc_enable |-> !ctl0_reg.bus_clock_source && !ctl0_reg.loop_ref_select)
    else $error("oscillator selection kept while disabled");

endmodule // crg_top

//--- verification/crg_xtal_model.sv
module crg_xtal_model (
    // Bench control
    input wire logic pclk,
    input wire logic run,
    // Board side
    input wire logic rst_pin_oe,
    output logic osc_tick,
    output logic rst_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'b00;
    initial osc_tick = 1'b0;
    // Stopped crystal gives no edges at all, so the monitor sees true silence
    always @(posedge pclk)
    begin
        ph <= ph + 2'd1;
        osc_tick <= run && ph == 2'd0;
    end
    // Pull-up on the board: a released pin reads high
    assign rst_pin = rst_pin_oe ? 1'b0 : 1'b1;
endmodule // crg_xtal_model

//--- verification/tb_clock_reset_generator.sv
module tb_clock_reset_generator;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic osc_tick_i, dco_tick_i = 0, irc_tick_i = 0, osc_started_i = 0, fll_locked_i = 0;
    logic trim_load_i = 0, rst_pin_i, rst_pin_o, rst_pin_oe, bus_clk_en_o, fll_ref_tick_o;
    logic dco_en_o, osc_en_o, osc_mon_en_o, osc_low_band_o, irc_en_o, lock_irq_o, run = 0;
    logic [9:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, seed = 2;
    logic [8:0] trim_value_i = 0, trim_o;
    logic [6:0] mult_o;
    logic [7:0] m = 0;
    logic err;
    int div_tab[7] = '{128, 160, 192, 256, 320, 384, 512};
    crg_pkg::crg_power_t power_i = '0;
    crg_pkg::crg_reset_src_t rst_src_i = '0;
    crg_pkg::crg_mode_t fll_mode_o;
    int errors = 0, checks = 0, n;
    always #12.5 pclk = ~pclk;
    crg_top dut (.*);
    crg_xtal_model xm (.pclk(pclk), .run(run), .rst_pin_oe(rst_pin_oe), .osc_tick(osc_tick_i),
        .rst_pin(rst_pin_i));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    always @(posedge pclk) {dco_tick_i, irc_tick_i} <= 2'(xs());
    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin errors++; $display("[FAIL] %s expected %h seen %h", s, e, g); end
    endtask
    task automatic apb(bit w, logic [7:0] idx, logic [7:0] d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= {24'(xs()), d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Reference model of the first control register
    // Spacing in cycles between two pulses of a one-cycle strobe
    task automatic gap(ref logic s, output int g);
        do @(posedge pclk); while (s !== 1'b1);
        g = 0;
        do
        begin
            @(posedge pclk);
            g++;
        end
        while (s !== 1'b1);
    endtask
    task automatic wr0(logic [7:0] d);
        apb(1, 8'h34, d);
        // Model after the write, so the start flag is the one the write edge saw
        m = {d[7], d[6:4], d[7] & d[3] & (osc_started_i | m[3]),
             d[7] & d[2] & (osc_started_i | m[2]), m[7] ? m[1] : d[1], 1'b0};
        apb(0, 8'h34, 0);
        chk("ctl0", m, rd);
        repeat (3) @(posedge pclk);
        chk("mode", !m[7] ? 0 : m[3] ? 2 : m[2], fll_mode_o);
        chk("dco_en", !(m[7] & m[3]), dco_en_o);
        chk("band", m[1], osc_low_band_o);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (50000) @(posedge pclk);
        errors++;
        finish_test();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk("rst outs", 0, {osc_en_o, osc_mon_en_o, rst_pin_oe, lock_irq_o, bus_clk_en_o});
        chk("rst mode", 32'hc, {dco_en_o, irc_en_o, fll_mode_o});
        apb(0, 8'h37, 0);
        chk("flags", 8'h40, rd);
        trim_value_i <= xs();
        trim_load_i <= 1;
        @(posedge pclk) trim_load_i <= 0;
        repeat (2) @(posedge pclk);
        chk("trim", trim_value_i, trim_o);
        run <= 1;
        wr0(8'h8c);
        osc_started_i <= 1;
        foreach (m[i]) if (i < 7)
        begin
            wr0({1'b1, 3'(i), 4'h4});
            gap(fll_ref_tick_o, n);
            chk("ref div", 4 * div_tab[i], n);
        end
        wr0(8'h88);
        apb(1, 8'h35, 8'h20);
        gap(bus_clk_en_o, n);
        chk("bus div", 24, n);
        wr0(8'h06);
        $display("clock select done");
        n = xs();
        apb(1, 8'h36, n[7:0]);
        repeat (2) @(posedge pclk);
        chk("mult", n[6:0], mult_o);
        apb(1, 8'h35, 8'h02);
        fll_locked_i <= 1;
        repeat (3) @(posedge pclk);
        apb(0, 8'h37, 0);
        chk("lock", 8'h5a, rd);
        chk("irq", 1, lock_irq_o);
        apb(1, 8'h37, 8'h10);
        apb(0, 8'h37, 0);
        chk("cleared", 8'h4a, rd);
        fll_locked_i <= 0;
        repeat (3) @(posedge pclk);
        apb(0, 8'h37, 0);
        chk("unlock", 8'h52, rd);
        apb(1, 8'h3a, 8'hff);
        apb(0, 8'h3a, 0);
        chk("test reg", 0, rd);
        apb(0, 8'h40, 0);
        chk("unmapped", 1, err);
        $display("lock and map done");
        wr0(8'h82);
        power_i <= 3'b101;
        @(posedge pclk) power_i <= 3'b001;
        repeat (3) @(posedge pclk);
        for (n = 0; n < 20; n++) @(posedge pclk) chk("stop", 5'h01,
            {bus_clk_en_o, osc_en_o, osc_mon_en_o, dco_en_o, irc_en_o});
        power_i <= 3'b010;
        @(posedge pclk) power_i <= 0;
        $display("stop done");
        wr0(8'h80);
        rst_src_i <= 3'b011;
        @(posedge pclk) rst_src_i <= 0;
        repeat (3) @(posedge pclk);
        chk("pin", 1, rst_pin_oe);
        repeat (200) @(posedge pclk);
        apb(0, 8'h37, 0);
        chk("illegal", 8'h46, rd);
        m = 0;
        wr0(8'h80);
        run <= 0;
        repeat (60) @(posedge pclk);
        chk("monitor", 1, rst_pin_oe);
        run <= 1;
        repeat (200) @(posedge pclk);
        apb(0, 8'h34, 0);
        chk("pin reset", 0, rd);
        $display("reset done");
        finish_test();
    end
endmodule // tb_clock_reset_generator
